// file: rngc_defs.svh
// Constants for the converter range control loop: register offsets,
// field positions, reset values and timing limits.
// Assumes inclusion by bare name from the package and the design module.
`ifndef RNGC_DEFS_SVH
`define RNGC_DEFS_SVH

// =====================================================
// Register byte offsets (Wishbone, one 32-bit word each)
`define RNGC_OFF_CTRL      8'h00
`define RNGC_OFF_IMM       8'h04
`define RNGC_OFF_AVG_THR   8'h08
`define RNGC_OFF_STEPS     8'h0c
`define RNGC_OFF_LIMITS    8'h10
`define RNGC_OFF_INTEG     8'h14
`define RNGC_OFF_SLOT      8'h18
`define RNGC_OFF_ACCUM     8'h1c
`define RNGC_OFF_DCOFS     8'h20
`define RNGC_OFF_AVGMAG    8'h24
`define RNGC_OFF_LUT       8'h28
`define RNGC_OFF_MAP       8'h2c
`define RNGC_OFF_STATUS    8'h30

// =====================================================
// Control register fields
`define RNGC_CTRL_BIAS_EN  0
`define RNGC_CTRL_SHIFT_LO 4
`define RNGC_CTRL_SHIFT_HI 8
`define RNGC_CTRL_DLY_LO   16
`define RNGC_CTRL_DLY_HI   23

// =====================================================
// Reset values
`define RNGC_RST_CTRL      32'h0000_0001
`define RNGC_RST_LIM_HI    16'hffff
`define RNGC_RST_LIM_LO    16'h0000
`define RNGC_RST_INTEG     16'h00ff
`define RNGC_RST_SLOT      16'hffff
`define RNGC_RST_MAP       8'he4

// =====================================================
// Widths and limits
`define RNGC_ACC_W         16
`define RNGC_SAMP_W        16
`define RNGC_DLY_DEPTH     256
`define RNGC_HPF_SHIFT     8

`endif

// file: rngc_pkg.sv
// Types for the converter range control loop.
// Assumes rngc_defs.svh is on the include path.
`include "rngc_defs.svh"

package rngc_pkg;

   // =====================================================
   // Wishbone request carrier
   typedef struct packed
   {
      logic        cyc;   // Cycle valid
      logic        stb;   // Strobe
      logic        we;    // Write enable
      logic [3:0]  sel;   // Byte selects
      logic [7:0]  adr;   // Byte address
      logic [31:0] dat;   // Write data
   } rngc_wb_req_s;

   // Averaged path timing phase
   typedef enum logic [1:0]
   {
      RNGC_DELAY,
      RNGC_INTEG,
      RNGC_IDLE
   } rngc_phase_e;

endpackage

// file: rngc_range_ctrl.sv
// Range control loop for one converter input: immediate and averaged
// detectors, limited attenuation accumulator, gain delay and code lookup.
// Assumes a Wishbone classic master on clk and converter samples on clk.
//
// Functional notes
// - Sample magnitude over threshold raises attenuation
// - Immediate increase beats averaged adjustment
// - Hold off immediate triggers after crossing
// - High pass filter before averaging
// - Integrate period 1 to 65536 samples
// - Shift integrator result by programmed power
// - Averaged compare only at period end
// - Above upper add increment, below lower subtract
// - Between thresholds add signed bias, disableable
// - Accumulator confined between programmable limits
// - Top three bits give attenuation step
// - Same bits drive compensating shifter gain
// - Gain bits delayed 1 to 256 clocks
// - Eight-entry 8-bit code lookup table
// - 16-bit attenuator code bus at channel rate
// - Bus mapping in four-bit groups
// - Counters pace only averaged path
// - Slot counter restarts on terminal or sync
// - Delay counter loaded with slot, starts integration
// - Integration time and period counters
// - Host writes and reads accumulator and monitors
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rngc_defs.svh"

module rngc_range_ctrl
   import rngc_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire rngc_wb_req_s               wb_req,
   output logic [31:0]                     wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic [`RNGC_SAMP_W-1:0]    adc_sample,
   input  wire logic                       slot_sync,
   input  wire logic                       channel_clock,
   output logic [15:0]                     attenuator_code_bus,
   output logic [2:0]                      shifter_gain
);

   // =====================================================
   // Input synchronisers for pins from outside the domain
   logic [1:0] sync_slot_ff;     // Slot sync pin
   logic [1:0] sync_cclk_ff;     // Channel clock pin
   logic       cclk_prev_ff;     // Edge detect of synced channel clock

   // Two flops each, second stage read by logic
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sync_slot_ff <= 2'h0;
         sync_cclk_ff <= 2'h0;
         cclk_prev_ff <= 1'b0;
      end
      else
      begin
         sync_slot_ff <= {sync_slot_ff[0], slot_sync};
         sync_cclk_ff <= {sync_cclk_ff[0], channel_clock};
         cclk_prev_ff <= sync_cclk_ff[1];
      end
   end

   logic cclk_rise;              // One rising edge of channel clock
   assign cclk_rise = sync_cclk_ff[1] & ~cclk_prev_ff;

   // =====================================================
   // Software registers
   logic [31:0] ctrl_ff;         // Bias enable, shift, gain delay
   logic [15:0] imm_thr_ff;      // Immediate magnitude threshold
   logic [15:0] imm_hold_ff;     // Hold-off sample count
   logic [15:0] imm_step_ff;     // Immediate attenuation step
   logic [15:0] upper_thr_ff;    // Averaged upper threshold
   logic [15:0] lower_thr_ff;    // Averaged lower threshold
   logic [15:0] inc_ff;          // Increment above upper
   logic [15:0] dec_ff;          // Decrement below lower
   logic [15:0] bias_ff;         // Signed bias between thresholds
   logic [15:0] lim_hi_ff;       // Accumulator upper limit
   logic [15:0] lim_lo_ff;       // Accumulator lower limit
   logic [15:0] integ_len_ff;    // Integration length minus one
   logic [15:0] per_count_ff;    // Periods per slot minus one
   logic [15:0] slot_len_ff;     // Slot length minus one
   logic [15:0] delay_len_ff;    // Delay before first period
   logic [7:0]  map_ff;          // Group sources for output bus
   logic [7:0]  lut_mem [0:7];   // Attenuator code table

   logic        wb_hit;          // Request seen, not yet answered
   logic        wb_wr;           // Write taking effect
   logic        acc_wr;          // Host load of the accumulator

   assign wb_hit = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   assign wb_wr  = wb_hit & wb_req.we;
   assign acc_wr = wb_wr & (wb_req.adr == `RNGC_OFF_ACCUM);

   // Lane-merging write helper
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   // Register writes; ack one cycle after request, dropped next cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ctrl_ff      <= `RNGC_RST_CTRL;
         imm_thr_ff   <= 16'h7000;
         imm_hold_ff  <= 16'h000c;
         imm_step_ff  <= 16'h2000;
         upper_thr_ff <= 16'h1000;
         lower_thr_ff <= 16'h0100;
         inc_ff       <= 16'h0100;
         dec_ff       <= 16'h0100;
         bias_ff      <= 16'h0000;
         lim_hi_ff    <= `RNGC_RST_LIM_HI;
         lim_lo_ff    <= `RNGC_RST_LIM_LO;
         integ_len_ff <= `RNGC_RST_INTEG;
         per_count_ff <= 16'h0000;
         slot_len_ff  <= `RNGC_RST_SLOT;
         delay_len_ff <= 16'h0000;
         map_ff       <= `RNGC_RST_MAP;
      end
      else if (wb_wr)
      begin
         case (wb_req.adr)
            `RNGC_OFF_CTRL:    ctrl_ff <= merge(ctrl_ff, wb_req.dat, wb_req.sel);
            `RNGC_OFF_IMM:     {imm_hold_ff, imm_thr_ff} <=
                                  merge({imm_hold_ff, imm_thr_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_AVG_THR: {upper_thr_ff, lower_thr_ff} <=
                                  merge({upper_thr_ff, lower_thr_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_STEPS:   {inc_ff, dec_ff} <= merge({inc_ff, dec_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_LIMITS:  {lim_hi_ff, lim_lo_ff} <=
                                  merge({lim_hi_ff, lim_lo_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_INTEG:   {per_count_ff, integ_len_ff} <=
                                  merge({per_count_ff, integ_len_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_SLOT:    {delay_len_ff, slot_len_ff} <=
                                  merge({delay_len_ff, slot_len_ff}, wb_req.dat, wb_req.sel);
            `RNGC_OFF_MAP:     {imm_step_ff, bias_ff, map_ff} <=
                                  {merge({imm_step_ff, bias_ff}, wb_req.dat, wb_req.sel),
                                   map_ff};
            `RNGC_OFF_STATUS:  map_ff <= wb_req.sel[0] ? wb_req.dat[7:0] : map_ff;
            default:           ctrl_ff <= ctrl_ff;   // Unmapped: write ignored
         endcase
      end
   end

   // Lookup table load: data[7:0] code, data[10:8] entry
   always_ff @(posedge clk)
   begin
      if (wb_wr && wb_req.adr == `RNGC_OFF_LUT && wb_req.sel[0])
         lut_mem[wb_req.dat[10:8]] <= wb_req.dat[7:0];
   end

   // =====================================================
   // Immediate detector
   logic [15:0] mag;             // Magnitude of current sample
   logic [15:0] hold_cnt_ff;     // Hold-off remaining samples
   logic        imm_fire;        // Immediate increase this cycle

   // Absolute value, saturating the most negative code
   function automatic logic [15:0] absval(input logic [15:0] v);
      if (!v[15])
         return v;
      else if (v == 16'h8000)
         return 16'h7fff;
      else
         return 16'(-v);
   endfunction

   assign mag      = absval(adc_sample);
   assign imm_fire = (mag > imm_thr_ff) && (hold_cnt_ff == 16'h0000);

   // Hold-off counter reloads on every trigger
   always_ff @(posedge clk)
   begin
      if (!resetn)
         hold_cnt_ff <= 16'h0000;
      else if (imm_fire)
         hold_cnt_ff <= imm_hold_ff;
      else if (hold_cnt_ff != 16'h0000)
         hold_cnt_ff <= hold_cnt_ff - 16'h0001;
   end

   // =====================================================
   // High-pass filter: leaky DC estimate subtracted from input
   logic signed [31:0] dc_ff;    // DC estimate, 16 fraction bits
   logic signed [16:0] hp_val;   // Input minus DC

   assign hp_val = 17'($signed(adc_sample)) - 17'(dc_ff >>> 16);

   // Estimate tracks the residue slowly
   always_ff @(posedge clk)
   begin
      if (!resetn)
         dc_ff <= 32'sh0;
      else
         dc_ff <= dc_ff + (32'($signed(hp_val)) <<< (16 - `RNGC_HPF_SHIFT));
   end

   // =====================================================
   // Timing counters: slot, delay, integration time, period count
   rngc_phase_e phase_ff;        // Averaged path phase
   logic [15:0] slot_cnt_ff;     // Slot position
   logic [15:0] dly_cnt_ff;      // Delay remaining
   logic [15:0] int_cnt_ff;      // Integration position
   logic [15:0] per_cnt_ff;      // Periods done in slot
   logic        slot_restart;    // Terminal count or sync
   logic        period_end;      // Integration period ends now

   assign slot_restart = (slot_cnt_ff == slot_len_ff) || sync_slot_ff[1];
   assign period_end   = (phase_ff == RNGC_INTEG) && (int_cnt_ff == integ_len_ff);

   // Slot counter
   always_ff @(posedge clk)
   begin
      if (!resetn || slot_restart)
         slot_cnt_ff <= 16'h0000;
      else
         slot_cnt_ff <= slot_cnt_ff + 16'h0001;
   end

   // Phase sequencing through one slot
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         phase_ff   <= RNGC_DELAY;
         dly_cnt_ff <= 16'h0000;
         int_cnt_ff <= 16'h0000;
         per_cnt_ff <= 16'h0000;
      end
      else if (slot_restart)
      begin
         phase_ff   <= RNGC_DELAY;
         dly_cnt_ff <= delay_len_ff;
         int_cnt_ff <= 16'h0000;
         per_cnt_ff <= 16'h0000;
      end
      else
      begin
         case (phase_ff)
            RNGC_DELAY:
            begin
               if (dly_cnt_ff == 16'h0000)
                  phase_ff <= RNGC_INTEG;
               else
                  dly_cnt_ff <= dly_cnt_ff - 16'h0001;
            end
            RNGC_INTEG:
            begin
               if (period_end)
               begin
                  int_cnt_ff <= 16'h0000;
                  per_cnt_ff <= per_cnt_ff + 16'h0001;
                  if (per_cnt_ff == per_count_ff)
                     phase_ff <= RNGC_IDLE;
               end
               else
                  int_cnt_ff <= int_cnt_ff + 16'h0001;
            end
            RNGC_IDLE:
               phase_ff <= RNGC_IDLE;                  // Wait for next slot
            default:
               phase_ff <= RNGC_IDLE;
         endcase
      end
   end

   // =====================================================
   // Integrate and dump, normalise
   logic [31:0] integ_ff;        // Magnitude sum
   logic [15:0] avg_mag_ff;      // Normalised average, held
   logic [31:0] integ_sum;       // Sum including this sample
   logic [31:0] norm;            // Shifted sum

   assign integ_sum = integ_ff + 32'(absval(hp_val[16:1]));
   assign norm      = integ_sum >> ctrl_ff[`RNGC_CTRL_SHIFT_HI:`RNGC_CTRL_SHIFT_LO];

   // Dump at period end so each period starts clean
   always_ff @(posedge clk)
   begin
      if (!resetn || slot_restart)
         integ_ff <= 32'h0;
      else if (period_end)
         integ_ff <= 32'h0;
      else if (phase_ff == RNGC_INTEG)
         integ_ff <= integ_sum;
   end

   // Held result for host monitoring
   always_ff @(posedge clk)
   begin
      if (!resetn)
         avg_mag_ff <= 16'h0000;
      else if (period_end)
         avg_mag_ff <= (norm[31:16] != 16'h0) ? 16'hffff : norm[15:0];
   end

   // =====================================================
   // Attenuation accumulator
   logic [15:0] acc_ff;          // Attenuation word
   logic [17:0] delta;           // Signed adjustment
   logic [17:0] acc_sum;         // Unclipped result
   logic [15:0] nxt_acc;         // Clipped result

   // Adjustment; immediate path wins over averaged decision
   always_comb
   begin
      delta = 18'h0;
      if (imm_fire)
         delta = {2'b00, imm_step_ff};
      else if (period_end)
      begin
         if (norm > 32'(upper_thr_ff))
            delta = {2'b00, inc_ff};
         else if (norm < 32'(lower_thr_ff))
            delta = 18'(-{2'b00, dec_ff});
         else if (ctrl_ff[`RNGC_CTRL_BIAS_EN])
            delta = {{2{bias_ff[15]}}, bias_ff};
      end
   end

   assign acc_sum = {2'b00, acc_ff} + delta;

   // Saturate at limits instead of wrapping
   always_comb
   begin
      if (acc_sum[17] || (acc_sum[16:0] < {1'b0, lim_lo_ff}))
         nxt_acc = lim_lo_ff;
      else if (acc_sum[16:0] > {1'b0, lim_hi_ff})
         nxt_acc = lim_hi_ff;
      else
         nxt_acc = acc_sum[15:0];
   end

   // Host load overrides the loop for that cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
         acc_ff <= `RNGC_RST_LIM_LO;
      else if (acc_wr)
         acc_ff <= wb_req.dat[15:0];
      else
         acc_ff <= nxt_acc;
   end

   // =====================================================
   // Gain delay line, 1 to 256 clocks
   logic [2:0] dly_mem [0:`RNGC_DLY_DEPTH-1];   // Circular gain history
   logic [7:0] wr_ptr_ff;        // Write position
   logic [7:0] rd_ptr;           // Read position

   assign rd_ptr = wr_ptr_ff - ctrl_ff[`RNGC_CTRL_DLY_HI:`RNGC_CTRL_DLY_LO];

   // Field value N gives N+1 clocks of delay
   always_ff @(posedge clk)
   begin
      if (!resetn)
         wr_ptr_ff <= 8'h00;
      else
         wr_ptr_ff <= wr_ptr_ff + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      dly_mem[wr_ptr_ff] <= acc_ff[15:13];
   end

   // Shifter gain: +6 dB per attenuation step
   // Field zero would read the slot being overwritten (257 clocks), so it bypasses the ring
   always_ff @(posedge clk)
   begin
      if (!resetn)
         shifter_gain <= 3'h0;
      else if (ctrl_ff[`RNGC_CTRL_DLY_HI:`RNGC_CTRL_DLY_LO] == 8'h00)
         shifter_gain <= acc_ff[15:13];
      else
         shifter_gain <= dly_mem[rd_ptr];
   end

   // =====================================================
   // Attenuator code bus, updated on channel clock rising edges
   logic [7:0] att_code;         // Looked-up code

   assign att_code = lut_mem[acc_ff[15:13]];

   // Each 4-bit group takes the low or high nibble as mapped
   always_ff @(posedge clk)
   begin
      if (!resetn)
         attenuator_code_bus <= 16'h0000;
      else if (cclk_rise)
         for (int g = 0; g < 4; g++)
            attenuator_code_bus[g*4 +: 4] <= map_ff[g*2] ? att_code[7:4] : att_code[3:0];
   end

   // =====================================================
   // Read data path
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_hit;
         case (wb_req.adr)
            `RNGC_OFF_CTRL:    wb_dat_o <= ctrl_ff;
            `RNGC_OFF_IMM:     wb_dat_o <= {imm_hold_ff, imm_thr_ff};
            `RNGC_OFF_AVG_THR: wb_dat_o <= {upper_thr_ff, lower_thr_ff};
            `RNGC_OFF_STEPS:   wb_dat_o <= {inc_ff, dec_ff};
            `RNGC_OFF_LIMITS:  wb_dat_o <= {lim_hi_ff, lim_lo_ff};
            `RNGC_OFF_INTEG:   wb_dat_o <= {per_count_ff, integ_len_ff};
            `RNGC_OFF_SLOT:    wb_dat_o <= {delay_len_ff, slot_len_ff};
            `RNGC_OFF_ACCUM:   wb_dat_o <= {16'h0, acc_ff};
            `RNGC_OFF_DCOFS:   wb_dat_o <= {16'h0, dc_ff[31:16]};
            `RNGC_OFF_AVGMAG:  wb_dat_o <= {16'h0, avg_mag_ff};
            `RNGC_OFF_MAP:     wb_dat_o <= {imm_step_ff, bias_ff};
            `RNGC_OFF_STATUS:  wb_dat_o <= {13'h0, shifter_gain, 6'h0, phase_ff, map_ff};
            default:           wb_dat_o <= 32'h0;      // Unmapped reads zero
         endcase
      end
   end

endmodule

// file: rngc_range_ctrl_assertions.sv
// Port checker for the converter range control block.
// Assumes one clock domain and a bound rngc_range_ctrl instance.
`timescale 1ns/10ps
module rngc_chk
   import rngc_pkg::*;
(
   input wire logic         clk,
   input wire logic         resetn,
   input wire rngc_wb_req_s wb_req,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic [15:0]  adc_sample,
   input wire logic         slot_sync,
   input wire logic         channel_clock,
   input wire logic [15:0]  attenuator_code_bus,
   input wire logic [2:0]   shifter_gain
);
   // =====================================================
   // Clocking and helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire rq = wb_req.cyc && wb_req.stb; // Request present
   // =====================================================
   // Bus handshake
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_next; rq && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");
   property p_ack_cause; wb_ack_o |-> $past(rq); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rst_quiet; $past(!resetn) |-> !wb_ack_o && wb_dat_o == 32'h0 && attenuator_code_bus == 16'h0; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   // Reads of holes and of the write-only table give zero
   property p_unmapped; wb_ack_o && $past(!wb_req.we && wb_req.adr > 8'h33) |-> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_lut_read; wb_ack_o && $past(!wb_req.we && wb_req.adr == 8'h28) |-> wb_dat_o == 32'h0; endproperty
   a_lut_read: assert property (p_lut_read) else $error("table read not zero");
   // =====================================================
   // Code bus pacing by the channel clock
   property p_bus_pace;
      $changed(attenuator_code_bus) |-> $past(channel_clock, 2) || $past(channel_clock, 3)
         || $past(channel_clock, 4) || $past(channel_clock, 5);
   endproperty
   a_bus_pace: assert property (p_bus_pace) else $error("code bus moved off channel clock");
   property p_bus_quiet; !channel_clock [*8] |-> $stable(attenuator_code_bus); endproperty
   a_bus_quiet: assert property (p_bus_quiet) else $error("code bus moved while channel clock idle");
   // Main scenarios seen
   c_read: cover property (wb_ack_o && $past(!wb_req.we));
   c_bus: cover property ($changed(attenuator_code_bus));
   c_sync: cover property (slot_sync);
endmodule

bind rngc_range_ctrl rngc_chk rngc_chk_inst
(
   .clk                 (clk),
   .resetn              (resetn),
   .wb_req              (wb_req),
   .wb_dat_o            (wb_dat_o),
   .wb_ack_o            (wb_ack_o),
   .adc_sample          (adc_sample),
   .slot_sync           (slot_sync),
   .channel_clock       (channel_clock),
   .attenuator_code_bus (attenuator_code_bus),
   .shifter_gain        (shifter_gain)
);

// file: rngc_adc_model.sv
// Converter stand-in: zero-mean tone plus offset, and the channel clock.
// Assumes the bench sets amplitude, offset and channel clock enable.
`timescale 1ns/10ps
module rngc_adc_model
(
   input  wire logic        clk,
   input  wire logic [15:0] amp,
   input  wire logic [15:0] ofs,
   input  wire logic        cc_en,
   output logic [15:0]      adc_sample,
   output logic             channel_clock
);
   logic [3:0] ph_ff = 4'h0;  // Channel clock phase
   logic       sgn_ff = 1'b0; // Sample sign
   // =====================================================
   // Tone at half the sample rate; offset tests the DC blocker
   always_ff @(posedge clk)
   begin
      sgn_ff <= !sgn_ff;
      adc_sample <= (sgn_ff ? amp : -amp) + ofs;
      ph_ff <= ph_ff + 4'h1;
      // Held still until the table is loaded
      channel_clock <= cc_en && (ph_ff < 4'h4);
   end
endmodule

// file: test_rngc_range_ctrl.sv
// Bench for the range control block over classic Wishbone.
// Assumes rngc_adc_model as the converter side.
`timescale 1ns/10ps
module test_rngc_range_ctrl
   import rngc_pkg::*;
;
   logic         clk, resetn, ack, cc_en, sync, cclk; // Bench wiring
   rngc_wb_req_s req;                                 // Bus request
   logic [31:0]  rdat, q, p;                          // Read data
   logic [15:0]  amp, ofs, adc, bus;                  // Samples, code bus
   logic [2:0]   gain;                                // Shifter gain
   logic [7:0]   c;                                   // Expected code
   int           n_mismatch, n_tests, k;              // Counters
   // =====================================================
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end
   rngc_range_ctrl rngc_range_ctrl_inst
   (
      .clk(clk), .resetn(resetn), .wb_req(req), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_sample(adc),
      .slot_sync(sync), .channel_clock(cclk), .attenuator_code_bus(bus), .shifter_gain(gain)
   );
   rngc_adc_model rngc_adc_model_inst
   (
      .clk(clk), .amp(amp), .ofs(ofs), .cc_en(cc_en), .adc_sample(adc), .channel_clock(cclk)
   );
   // =====================================================
   // Tasks
   function automatic logic [7:0] code(input int i);
      return {1'b0, i[2:0], 4'hf - i[3:0]}; // Distinct nibbles per step
   endfunction
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, 4'hf, a, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      if (ack !== 1'b1)
      begin
         n_mismatch++; // Answer never came
         results();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // =====================================================
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      req = '0;
      amp = 16'h0;
      ofs = 16'h0;
      cc_en = 1'b0;
      sync = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h00, 32'h1);
      rd(8'h10, 32'hffff_0000);
      wr(8'h3c, 32'h1234_5678);
      rd(8'h3c, 32'h0);
      for (k = 0; k < 8; k++)
         wr(8'h28, {21'h0, k[2:0], code(k)});
      rd(8'h28, 32'h0);
      cc_en <= 1'b1;
      // Averaged path parked: huge shift, open thresholds, no bias
      wr(8'h00, 32'h0000_00f0);
      wr(8'h08, 32'hffff_0000);
      wr(8'h0c, 32'h0);
      wr(8'h2c, 32'h2000_0000);
      wr(8'h14, 32'h0000_0003);
      wr(8'h18, 32'h0000_003f);
      wr(8'h04, 32'h0040_1000);
      wr(8'h1c, 32'h0);
      $display("test reset done");
      amp <= 16'h3000;
      idle(20);
      amp <= 16'h0;
      idle(4);
      rd(8'h1c, 32'h2000);
      wr(8'h10, 32'h5000_0000);
      amp <= 16'h3000;
      idle(400);
      amp <= 16'h0;
      rd(8'h1c, 32'h5000);
      chk(gain, 32'h2);
      $display("test immediate done");
      // Offset larger than tone: halved magnitudes give 0x800 only with a working DC blocker
      wr(8'h10, 32'hffff_0000);
      wr(8'h04, 32'h0040_7fff);
      wr(8'h00, 32'h0000_0020);
      wr(8'h08, 32'h0010_0000);
      wr(8'h0c, 32'h0100_0100);
      wr(8'h1c, 32'h0);
      amp <= 16'h1000;
      ofs <= 16'h2000;
      idle(200);
      sync <= 1'b1;
      idle(3);
      // Sync held: slot restarts every cycle, phase pinned at delay
      wb(1'b0, 8'h30, 32'h0);
      chk(q[9:8], 32'h0);
      sync <= 1'b0;
      idle(200);
      wb(1'b0, 8'h1c, 32'h0);
      chk(q[7:0] == 8'h0 && q[15:0] != 16'h0, 32'h1);
      wr(8'h08, 32'hffff_fff0);
      idle(1500);
      rd(8'h1c, 32'h0);
      wb(1'b0, 8'h24, 32'h0);
      chk(q >= 32'h07c0 && q <= 32'h0840, 32'h1);
      $display("test averaged done");
      wr(8'h08, 32'hffff_0000);
      wr(8'h2c, 32'h2000_0010);
      wr(8'h00, 32'h0000_0021);
      idle(400);
      wb(1'b0, 8'h1c, 32'h0);
      chk(q[3:0] == 4'h0 && q[15:0] != 16'h0, 32'h1);
      wr(8'h00, 32'h0000_0020);
      wb(1'b0, 8'h1c, 32'h0);
      p = q;
      idle(400);
      rd(8'h1c, p);
      $display("test bias done");
      amp <= 16'h0;
      ofs <= 16'h0;
      // Low accumulator bits set to show only the top three matter
      for (k = 0; k < 8; k++)
      begin
         wr(8'h1c, {16'h0, k[2:0], 13'h1fff});
         idle(40);
         chk(bus, {code(k), code(k)});
      end
      c = code(7);
      wr(8'h30, 32'h55);
      idle(40);
      chk(bus, {4{c[7:4]}});
      wr(8'h30, 32'h00);
      idle(40);
      chk(bus, {4{c[3:0]}});
      $display("test code bus done");
      wr(8'h00, 32'h0014_0020);
      wr(8'h1c, 32'h0);
      idle(300);
      wr(8'h1c, 32'he000);
      k = 0;
      while (gain !== 3'h7 && k < 60)
      begin
         @(posedge clk);
         k++;
      end
      chk(k >= 16 && k <= 23, 32'h1);
      $display("test gain delay done");
      results();
   end
endmodule
